// *** shared/scd_pkg.sv ***
// Package with constants and types for the serial control-byte decoder.
// What the host sends and how this block reads it
// [R01] Control byte: bits 7..3 target block, bit 2 direction, bits 1..0 length mode.
// [R02] Eight sockets each with register, transmit and receive blocks; 00000 picks common space.
// [R03] Low bits 01 select register block of socket given by upper three bits.
// [R04] Low bits 10 select transmit buffer of socket given by upper three bits.
// [R05] Low bits 11 select receive buffer of socket given by upper three bits.
// [R06] Host never sends nonzero target code whose low two bits are 00.
// [R07] Direction bit zero means read, one means write for the data phase.
// [R08] With per-frame chip select the host sends length mode 00.
// [R09] A sixteen-bit offset, most significant bit first, precedes the control byte.
// [R10] Socket index is upper three bits, type lower two; flag reserved nonzero type 00.
package scd_pkg;
  localparam int ADDR_BITS = 16;
  localparam int CTRL_BITS = 8;
  localparam int SEL_MSB = 7;
  localparam int SEL_LSB = 3;
  localparam int DIR_POS = 2;
  localparam int MODE_MSB = 1;
  localparam int MODE_LSB = 0;
  localparam int SOCK_MSB = 4;
  localparam int SOCK_LSB = 2;
  localparam int FRAME_BITS = ADDR_BITS + CTRL_BITS;
  localparam logic [1:0] TYPE_COMMON = 2'h0;
  localparam logic [1:0] TYPE_REG = 2'h1;
  localparam logic [1:0] TYPE_TX = 2'h2;
  localparam logic [1:0] TYPE_RX = 2'h3;
  localparam logic [1:0] MODE_VARIABLE = 2'h0;

  // Kind of block a control byte addresses.
  typedef enum logic [2:0] {
    SCD_BLK_COMMON,
    SCD_BLK_SOCK_REG,
    SCD_BLK_SOCK_TX,
    SCD_BLK_SOCK_RX,
    SCD_BLK_RESERVED
  } scd_block_t;
endpackage : scd_pkg

// *** verilog/scd_link_shift.sv ***
// Link-side shifter: collects offset and control byte on the serial clock.
`timescale 1ns/1ps
`default_nettype none
module scd_link_shift (
  input wire logic sclk,
  input wire logic rst_n,
  input wire logic chip_select_n,
  input wire logic mosi,
  output logic [scd_pkg::FRAME_BITS-1:0] frame_word,
  output logic frame_toggle
);
  logic [scd_pkg::FRAME_BITS-1:0] shift_reg;
  logic [scd_pkg::FRAME_BITS-1:0] shift_next;
  logic [4:0] count_reg;
  logic [4:0] count_next;
  logic done_reg;
  logic done_next;
  logic [scd_pkg::FRAME_BITS-1:0] word_reg;
  logic [scd_pkg::FRAME_BITS-1:0] word_next;
  logic tog_reg;
  logic tog_next;

  // Bits arrive MSB first; after 24 bits the word is held and a toggle flips.
  // Chip select is an asynchronous frame reset here because the serial clock
  // stops between frames and cannot clear the counter on its own.
  always_comb
  begin
    shift_next = {shift_reg[scd_pkg::FRAME_BITS-2:0], mosi}; // [R09]
    count_next = count_reg;
    done_next = done_reg;
    word_next = word_reg;
    tog_next = tog_reg;
    if (!done_reg)
    begin
      count_next = count_reg + 5'h01;
      if (count_reg == 5'(scd_pkg::FRAME_BITS - 1))
      begin
        done_next = 1'b1;
        word_next = shift_next;
        tog_next = ~tog_reg;
      end
    end
  end

  // Frame counters clear with chip select high; the result and toggle persist.
  always_ff @(posedge sclk or posedge chip_select_n)
  begin
    if (chip_select_n)
    begin
      count_reg <= 5'h00;
      done_reg <= 1'b0;
      shift_reg <= '0;
    end
    else
    begin
      count_reg <= count_next;
      done_reg <= done_next;
      shift_reg <= shift_next;
    end
  end

  // Captured word and toggle only change at the end of the control byte. The
  // toggle needs a known start, or the system side could never see it change;
  // rst_n clears it while the serial clock is stopped, so no edge races it.
  always_ff @(posedge sclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      word_reg <= '0;
      tog_reg <= 1'b0;
    end
    else
    begin
      word_reg <= word_next;
      tog_reg <= tog_next;
    end
  end

  assign frame_word = word_reg;
  assign frame_toggle = tog_reg;
endmodule : scd_link_shift
`default_nettype wire

// *** verilog/scd_control_decode.sv ***
// Top level: decodes the control byte of each serial frame into the system clock domain.
`timescale 1ns/1ps
`default_nettype none
// The serial side shifts in a 16-bit offset and an 8-bit control byte on the
// serial clock and hands the finished 24-bit word over with a toggle. The
// system side synchronises the toggle, and on each change registers the offset,
// the five-bit target code, the socket number, a one-hot block kind, the
// reserved flag, the direction bit and the length mode, and pulses ctrl_valid
// for one enabled cycle.
//
// Limitations a user must know:
// - Only chip-select-framed transfers are understood. With chip select tied
//   low the bit counter is never cleared, so only the first frame decodes.
// - Consecutive frames must be at least about three clk cycles apart, or two
//   toggle changes can fall inside the synchroniser and a decode is lost.
// - Reserved target codes are decoded, not refused: block_reserved rises and
//   every block select stays low, so the owner of the outputs can ignore them.
// - The length mode is only reported; variable_length_mode marks mode 00.
// - Data-phase bits after the control byte are ignored here.
//
// Reset: rst_n is synchronous for the system side. It also clears the link
// toggle asynchronously; that is safe because the serial clock is stopped
// while the block is held in reset, so no serial edge can race its release.
module scd_control_decode (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic sclk,
  input wire logic chip_select_n,
  input wire logic mosi,
  output logic [scd_pkg::ADDR_BITS-1:0] offset_addr,
  output logic [4:0] target_block_select,
  output logic [2:0] socket_index,
  output logic sel_common,
  output logic sel_sock_reg,
  output logic sel_sock_tx,
  output logic sel_sock_rx,
  output logic block_reserved,
  output logic access_direction_bit,
  output logic [1:0] operation_length_mode,
  output logic variable_length_mode,
  output logic ctrl_valid
);
  logic [scd_pkg::FRAME_BITS-1:0] link_word;
  logic link_tog;
  logic [2:0] tog_sync_reg;
  logic [2:0] tog_sync_next;
  // Registered offset, target code and socket number.
  logic [scd_pkg::ADDR_BITS-1:0] off_reg;
  logic [scd_pkg::ADDR_BITS-1:0] off_next;
  logic [4:0] sel_reg;
  logic [4:0] sel_next;
  logic [2:0] sock_reg;
  logic [2:0] sock_next;
  // One-hot block kind and the reserved flag.
  logic com_reg;
  logic com_next;
  logic sreg_reg;
  logic sreg_next;
  logic tx_reg;
  logic tx_next;
  logic rx_reg;
  logic rx_next;
  logic rsv_reg;
  logic rsv_next;
  // Direction, length mode and the decode pulse.
  logic dir_reg;
  logic dir_next;
  logic [1:0] mode_reg;
  logic [1:0] mode_next;
  logic vdm_reg;
  logic vdm_next;
  logic vld_reg;
  logic vld_next;
  logic new_frame;
  logic [scd_pkg::CTRL_BITS-1:0] ctrl;
  scd_pkg::scd_block_t kind;

  // Classifies a five-bit target code by its low two bits.
  // The all-zero code is tested first because its low bits also read as 00,
  // which for every other code means a reserved value.
  function automatic scd_pkg::scd_block_t classify(input logic [4:0] code);
    logic [1:0] typ;
    typ = code[1:0];
    if (code == 5'h00)
      return scd_pkg::SCD_BLK_COMMON; // [R02]
    else if (typ == scd_pkg::TYPE_REG)
      return scd_pkg::SCD_BLK_SOCK_REG; // [R03]
    else if (typ == scd_pkg::TYPE_TX)
      return scd_pkg::SCD_BLK_SOCK_TX; // [R04]
    else if (typ == scd_pkg::TYPE_RX)
      return scd_pkg::SCD_BLK_SOCK_RX; // [R05]
    else
      return scd_pkg::SCD_BLK_RESERVED; // [R10]
  endfunction : classify

  scd_link_shift u_link (
    .rst_n(rst_n),
    .sclk(sclk),
    .chip_select_n(chip_select_n),
    .mosi(mosi),
    .frame_word(link_word),
    .frame_toggle(link_tog)
  );

  // Two-flop synchroniser plus one history flop for the link toggle. The word
  // itself is not synchronised: it stands still from the 24th serial edge until
  // the next frame completes, far longer than the three clk cycles the toggle
  // needs to cross, so it is sampled only once the edge is seen.
  always_comb
  begin
    tog_sync_next = {tog_sync_reg[1:0], link_tog};
  end

  // Synchroniser registers; they freeze with the rest while clk_en is low.
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      tog_sync_reg <= 3'h0; // Matches the reset level of the link toggle.
    end
    else if (clk_en)
    begin
      tog_sync_reg <= tog_sync_next;
    end
  end

  // Decode of the captured word. A toggle edge that arrives while clk_en is
  // low is picked up once clk_en returns, since the synchroniser is frozen too.
  always_comb
  begin
    new_frame = tog_sync_reg[2] ^ tog_sync_reg[1];
    ctrl = link_word[scd_pkg::CTRL_BITS-1:0];
    kind = classify(ctrl[scd_pkg::SEL_MSB:scd_pkg::SEL_LSB]); // [R01]
    off_next = off_reg;
    sel_next = sel_reg;
    sock_next = sock_reg;
    com_next = com_reg;
    sreg_next = sreg_reg;
    tx_next = tx_reg;
    rx_next = rx_reg;
    rsv_next = rsv_reg;
    dir_next = dir_reg;
    mode_next = mode_reg;
    vdm_next = vdm_reg;
    vld_next = 1'b0;
    // Everything is taken from the same captured word in one cycle, so the
    // outputs never show an offset from one frame with a block from another.
    if (new_frame)
    begin
      off_next = link_word[scd_pkg::FRAME_BITS-1:scd_pkg::CTRL_BITS]; // [R09]
      sel_next = ctrl[scd_pkg::SEL_MSB:scd_pkg::SEL_LSB]; // [R01]
      sock_next = sel_next[scd_pkg::SOCK_MSB:scd_pkg::SOCK_LSB]; // [R10]
      com_next = (kind == scd_pkg::SCD_BLK_COMMON); // [R02]
      sreg_next = (kind == scd_pkg::SCD_BLK_SOCK_REG); // [R03]
      tx_next = (kind == scd_pkg::SCD_BLK_SOCK_TX); // [R04]
      rx_next = (kind == scd_pkg::SCD_BLK_SOCK_RX); // [R05]
      rsv_next = (kind == scd_pkg::SCD_BLK_RESERVED); // [R10]
      dir_next = ctrl[scd_pkg::DIR_POS]; // [R07]
      mode_next = ctrl[scd_pkg::MODE_MSB:scd_pkg::MODE_LSB]; // [R01]
      vdm_next = (mode_next == scd_pkg::MODE_VARIABLE); // [R08]
      vld_next = 1'b1;
    end
  end

  // Registers all decoded fields; clock enable low freezes everything.
  // Holding the fields between frames lets a slow consumer read them at
  // leisure; only ctrl_valid marks that they have just changed.
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      // Every output reads zero until the first frame is decoded.
      off_reg <= 16'h0000;
      sel_reg <= 5'h00;
      sock_reg <= 3'h0;
      com_reg <= 1'b0;
      sreg_reg <= 1'b0;
      tx_reg <= 1'b0;
      rx_reg <= 1'b0;
      rsv_reg <= 1'b0;
      dir_reg <= 1'b0;
      mode_reg <= 2'h0;
      vdm_reg <= 1'b0;
      vld_reg <= 1'b0;
    end
    else if (clk_en)
    begin
      off_reg <= off_next;
      sel_reg <= sel_next;
      sock_reg <= sock_next;
      com_reg <= com_next;
      sreg_reg <= sreg_next;
      tx_reg <= tx_next;
      rx_reg <= rx_next;
      rsv_reg <= rsv_next;
      dir_reg <= dir_next;
      mode_reg <= mode_next;
      vdm_reg <= vdm_next;
      vld_reg <= vld_next;
    end
  end

  // Offset, target code and socket number come straight from their registers.
  assign offset_addr = off_reg;
  assign target_block_select = sel_reg;
  assign socket_index = sock_reg;

  // The one-hot block kind and the reserved flag.
  assign sel_common = com_reg;
  assign sel_sock_reg = sreg_reg;
  assign sel_sock_tx = tx_reg;
  assign sel_sock_rx = rx_reg;
  assign block_reserved = rsv_reg;

  // Direction, length mode and the decode pulse.
  assign access_direction_bit = dir_reg;
  assign operation_length_mode = mode_reg;
  assign variable_length_mode = vdm_reg;
  assign ctrl_valid = vld_reg;
endmodule : scd_control_decode
`default_nettype wire

// *** dv/scd_control_decode_checker.sv ***
// Checker of the decoded control-byte outputs.
`timescale 1ns/1ps
`default_nettype none
module scd_control_decode_checker (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic [15:0] offset_addr,
  input wire logic [4:0] target_block_select,
  input wire logic [2:0] socket_index,
  input wire logic sel_common,
  input wire logic sel_sock_reg,
  input wire logic sel_sock_tx,
  input wire logic sel_sock_rx,
  input wire logic block_reserved,
  input wire logic [1:0] operation_length_mode,
  input wire logic variable_length_mode,
  input wire logic ctrl_valid
);
  logic seen_reg;
  // Reset leaves every output low, so decode relations hold only after a first decode.
  always_ff @(posedge clk) seen_reg <= rst_n & (seen_reg | ctrl_valid);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  a_sock_index: assert property (seen_reg |-> socket_index == target_block_select[4:2])
    else $error("socket index wrong");
  a_common_sel: assert property (seen_reg |-> sel_common == (target_block_select == 5'h00))
    else $error("common select wrong");
  a_reg_sel: assert property (seen_reg |-> sel_sock_reg == (target_block_select[1:0] == 2'h1))
    else $error("register select wrong");
  a_tx_sel: assert property (seen_reg |-> sel_sock_tx == (target_block_select[1:0] == 2'h2))
    else $error("transmit select wrong");
  a_rx_sel: assert property (seen_reg |-> sel_sock_rx == (target_block_select[1:0] == 2'h3))
    else $error("receive select wrong");
  a_resv_flag: assert property (seen_reg |-> block_reserved ==
    (target_block_select != 5'h00 && target_block_select[1:0] == 2'h0))
    else $error("reserved flag wrong");
  a_var_mode: assert property (seen_reg |-> variable_length_mode == (operation_length_mode == 2'h0))
    else $error("variable mode flag wrong");
  a_valid_pulse: assert property (ctrl_valid && clk_en |=> !ctrl_valid)
    else $error("decode pulse too long");
  a_fields_hold: assert property (!ctrl_valid |-> $stable(offset_addr) && $stable(target_block_select))
    else $error("fields changed without decode");
  a_en_freeze: assert property (!clk_en |=> $stable(ctrl_valid) && $stable(offset_addr))
    else $error("outputs moved while disabled");
endmodule : scd_control_decode_checker
`default_nettype wire

// *** dv/scd_host_model.sv ***
// Behavioural serial master that sends frames to the decoder.
`timescale 1ns/1ps
`default_nettype none
module scd_host_model (
  output var logic sclk,
  output var logic chip_select_n,
  output var logic mosi
);
  // Mode 0: the clock idles low and stands still between frames.
  initial
  begin
    sclk = 1'b0;
    chip_select_n = 1'b1;
    mosi = 1'b0;
  end
  // Sends the top n bits of w, most significant first, at a 64 ns serial period.
  task send(input logic [31:0] w, input int n);
    int i;
    #13 chip_select_n = 1'b0;
    for (i = 0; i < n; i++)
    begin
      mosi = w[31 - i];
      #32 sclk = 1'b1;
      #32 sclk = 1'b0;
    end
    #32 chip_select_n = 1'b1;
    mosi = ~mosi; // A released line must not keep showing the last bit.
  endtask : send
endmodule : scd_host_model
`default_nettype wire

// *** dv/scd_control_decode_test.sv ***
// Self-checking bench of the serial control-byte decoder.
`timescale 1ns/1ps
`default_nettype none
module scd_control_decode_test;
  logic clk = 1'b0;
  logic rst_n = 1'b1; // Dropped at time zero so the link toggle sees a reset edge.
  logic clk_en = 1'b1;
  logic sclk, chip_select_n, mosi, sel_common, sel_sock_reg, sel_sock_tx, sel_sock_rx;
  logic block_reserved, access_direction_bit, variable_length_mode, ctrl_valid;
  logic [15:0] offset_addr;
  logic [4:0] target_block_select;
  logic [2:0] socket_index;
  logic [1:0] operation_length_mode;
  int fails = 0;
  int comparisons = 0;
  int pulses = 0;
  // Clock, and a count of the one-cycle decode pulses so none is missed.
  always #25 clk = ~clk;
  always @(posedge clk) if (ctrl_valid === 1'b1) pulses <= pulses + 1;
  scd_host_model host (.sclk, .chip_select_n, .mosi);
  scd_control_decode dut (.clk, .rst_n, .clk_en, .sclk, .chip_select_n, .mosi, .offset_addr,
    .target_block_select, .socket_index, .sel_common, .sel_sock_reg, .sel_sock_tx, .sel_sock_rx,
    .block_reserved, .access_direction_bit, .operation_length_mode, .variable_length_mode,
    .ctrl_valid);
  task check(input logic [32:0] got, input logic [32:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      fails++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  task conclude;
    $display("%0d comparisons, %0d fails", comparisons, fails);
    if (fails == 0 && comparisons > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : conclude
  // Sends a frame and waits, within a bound, for the expected number of decodes.
  task frame(input logic [31:0] w, input int n, input int want);
    int p0;
    int i;
    p0 = pulses;
    host.send(w, n);
    for (i = 0; i < 12 && pulses == p0; i++) @(posedge clk);
    repeat (2) @(posedge clk);
    check(33'(pulses - p0), 33'(want));
    if (pulses - p0 != want) conclude();
  endtask : frame
  task expect_decode(input logic [15:0] a, input logic [7:0] c);
    logic [4:0] b;
    b = c[7:3];
    check(33'({offset_addr, target_block_select, access_direction_bit, operation_length_mode}),
      33'({a, c}));
    check(33'({socket_index, sel_common, sel_sock_reg, sel_sock_tx, sel_sock_rx, block_reserved,
      variable_length_mode}), 33'({b[4:2], b == 5'h00, b[1:0] == 2'h1, b[1:0] == 2'h2,
      b[1:0] == 2'h3, b != 5'h00 && b[1:0] == 2'h0, c[1:0] == 2'h0}));
  endtask : expect_decode
  // Every target code, reserved ones included, with direction and mode varied.
  task t_codes;
    int k;
    logic [15:0] a;
    logic [7:0] c;
    for (k = 0; k < 32; k++)
    begin
      a = 16'hc003 + 16'(k * 16'h0101);
      c = {5'(k), 1'(k >> 1), 2'(k + 1)};
      frame({a, c, 8'h00}, 24, 1);
      expect_decode(a, c);
    end
    $display("test codes done");
  endtask : t_codes
  // Data-phase bits after the control byte must not disturb the decode.
  task t_data_phase;
    frame(32'h8001_b5ff, 32, 1);
    expect_decode(16'h8001, 8'hb5);
    $display("test data phase done");
  endtask : t_data_phase
  // A frame cut one bit short of the control byte yields nothing.
  task t_abort;
    frame(32'h1234_5600, 23, 0);
    expect_decode(16'h8001, 8'hb5);
    $display("test abort done");
  endtask : t_abort
  // Outputs are zero after reset, and a first all-zero frame selects common space.
  task t_first;
    check(33'({offset_addr, target_block_select, socket_index, sel_common, sel_sock_reg,
      sel_sock_tx, sel_sock_rx, block_reserved, access_direction_bit, operation_length_mode,
      variable_length_mode}), 33'h0);
    frame(32'h0, 24, 1);
    expect_decode(16'h0000, 8'h00);
    $display("test first frame done");
  endtask : t_first
  // With clk_en low nothing moves; the frame is decoded once clk_en returns.
  task t_enable;
    int p0;
    int i;
    p0 = pulses;
    clk_en <= 1'b0;
    host.send(32'h4321_2d00, 24);
    repeat (8) @(posedge clk);
    check(33'(pulses - p0), 33'h0);
    check(33'(offset_addr), 33'h8001);
    clk_en <= 1'b1;
    for (i = 0; i < 12 && pulses == p0; i++) @(posedge clk);
    repeat (2) @(posedge clk);
    check(33'(pulses - p0), 33'h1);
    if (pulses - p0 != 1) conclude();
    expect_decode(16'h4321, 8'h2d);
    $display("test enable done");
  endtask : t_enable
  initial
  begin
    rst_n <= 1'b0;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    t_first();
    t_codes();
    t_data_phase();
    t_abort();
    t_enable();
    conclude();
  end
endmodule : scd_control_decode_test
bind scd_control_decode scd_control_decode_checker chk (.clk, .rst_n, .clk_en, .offset_addr,
  .target_block_select, .socket_index, .sel_common, .sel_sock_reg, .sel_sock_tx, .sel_sock_rx,
  .block_reserved, .operation_length_mode, .variable_length_mode, .ctrl_valid);
`default_nettype wire
